// >>> design/rdt_channel.sv
// One reload down-timer channel: prescaler, counter, run state, flag.
// Assumes strobes are single-cycle pulses from the top module.
`timescale 1ns/1ps
module rdt_channel
    import rdt_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rstn_in,
    rdt_ctl_if.chan   ctl
);
    logic [13:0] pre_q;
    logic [13:0] pre_mask;
    logic        tick;
    logic        uf;
    logic [15:0] cnt_q;
    logic        run_q;
    logic        uf_q;
    logic        flag_q;
    logic        irq_q;

    // Divider mask: code n needs 2^n clk ticks; reserved code never ticks
    assign pre_mask = (ctl.clk_div_sel > RDT_DIV_MAX) ? RDT_PRE_ALL
                    : RDT_PRE_W'((RDT_PRE_ONE << ctl.clk_div_sel) - 1'b1);
    assign tick = run_q && ((pre_q & pre_mask) == RDT_PRE_RST)
                  && (ctl.clk_div_sel != RDT_DIV_RSVD);
    assign uf = tick && (cnt_q == RDT_CNT_ZERO);

    // Free prescaler, cleared while stopped so each start is aligned
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pre_q <= RDT_PRE_RST;
        end else if (!run_q) begin
            pre_q <= RDT_PRE_RST;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // Counter: preset wins, reload on underflow, else count down
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= RDT_CNT_RST;
        end else if (ctl.timer_preset) begin
            cnt_q <= ctl.reload_value;
        end else if (uf) begin
            cnt_q <= ctl.reload_value;
        end else if (tick) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Run state; one-shot clears itself at underflow, new write wins
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_q <= 1'b0;
        end else if (ctl.run_wr) begin
            run_q <= ctl.run_wdata;
        end else if (uf && ctl.oneshot_sel) begin
            run_q <= 1'b0;
        end
    end

    // One-cycle underflow pulse, aligned with the reload edge
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            uf_q <= 1'b0;
        end else begin
            uf_q <= uf;
        end
    end

    // Sticky flag: set beats a simultaneous clear so no event is lost
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_q <= 1'b0;
        end else if (uf) begin
            flag_q <= 1'b1;
        end else if (ctl.flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    // Request level toward the interrupt controller, gated by enable
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ctl.underflow_irq_en && (flag_q || uf) &&
                     !(ctl.flag_clr && !uf);
        end
    end

    assign ctl.count          = cnt_q;
    assign ctl.running        = run_q;
    assign ctl.underflow      = uf_q;
    assign ctl.underflow_flag = flag_q;
    assign ctl.irq            = irq_q;
endmodule

// >>> design/rdt_ctl_if.sv
// Per-channel control and status bundle between the top and a channel.
// Assumes all signals are synchronous to the peripheral clock.
`timescale 1ns/1ps
interface rdt_ctl_if;
    import rdt_pkg::*;
    logic [3:0]  clk_div_sel;
    logic        oneshot_sel;
    logic [15:0] reload_value;
    logic        timer_preset;
    logic        run_wr;
    logic        run_wdata;
    logic        flag_clr;
    logic        underflow_irq_en;
    logic [15:0] count;
    logic        running;
    logic        underflow;
    logic        underflow_flag;
    logic        irq;
    modport top (output clk_div_sel, oneshot_sel, reload_value, timer_preset,
                 run_wr, run_wdata, flag_clr, underflow_irq_en,
                 input count, running, underflow, underflow_flag, irq);
    modport chan (input clk_div_sel, oneshot_sel, reload_value, timer_preset,
                  run_wr, run_wdata, flag_clr, underflow_irq_en,
                  output count, running, underflow, underflow_flag, irq);
endinterface

// >>> design/rdt_pkg.sv
// Constants and types for the three-channel reload down timer.
// Assumes a single peripheral clock; no register bus (plain ports).
package rdt_pkg;
    localparam int          RDT_NUM_CH      = 3;
    localparam int          RDT_CNT_W       = 16;
    localparam int          RDT_DIV_W       = 4;
    localparam int          RDT_PRE_W       = 14;
    localparam logic [15:0] RDT_CNT_RST     = 16'hFFFF;
    localparam logic [15:0] RDT_RELOAD_RST  = 16'h0000;
    localparam logic [15:0] RDT_CNT_ZERO    = 16'h0000;
    localparam logic [3:0]  RDT_DIV_RST     = 4'h0;
    localparam logic [3:0]  RDT_DIV_MAX     = 4'hE;
    localparam logic [3:0]  RDT_DIV_RSVD    = 4'hF;
    localparam logic [13:0] RDT_PRE_RST     = 14'h0000;
    localparam logic [13:0] RDT_PRE_ONE     = 14'h0001;
    localparam logic [13:0] RDT_PRE_ALL     = 14'h3FFF;
    localparam int          RDT_CH_ADC      = 0;
    localparam int          RDT_CH_SPI      = 1;
    localparam int          RDT_CH_I2C      = 2;
    typedef enum logic {RDT_MODE_REPEAT, RDT_MODE_ONESHOT} rdt_mode_t;
endpackage

// >>> design/rdt_top.sv
// Top of the three-channel reload down timer with plain control ports.
// Assumes software-side strobes are one-cycle pulses, synchronous to clk.
`timescale 1ns/1ps

// Overview of operation
// - Three identical channels, differing only in their control location.
// - Each channel has a 16-bit down counter and 16-bit reload register.
// - Count clock is clock divided by 2^code; code 0xF is reserved.
// - Mode bit: 0 selects repeat, 1 selects one-shot; default repeat.
// - Repeat mode reloads at underflow and keeps counting.
// - One-shot mode reloads at underflow then stops itself.
// - Underflow period is reload value plus one count-clock periods.
// - Preset strobe loads counter from the reload register.
// - Run write of 1 counts down from current counter contents.
// - Run write of 0 stops; counter holds its value.
// - Underflow gives pulse, reload and interrupt request together.
// - Channel 0 triggers converter, 1 clocks SPI, 2 clocks I2C master.
// - Each channel has a flag set on its underflow.
// - Request reaches interrupt controller only while enable is 1.
// - Clear strobe clears the flag; absence leaves it unchanged.
// - Counter is read-only and reads 0xFFFF after reset.
// - Preset bit always reads back as 0.
// - Reload register is full 16-bit read/write, reset 0x0.
module rdt_top
    import rdt_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic [11:0] clk_div_sel_in,
    input  wire logic [2:0]  oneshot_sel_in,
    input  wire logic [2:0]  reload_wr_in,
    input  wire logic [47:0] reload_wdata_in,
    input  wire logic [2:0]  timer_preset_in,
    input  wire logic [2:0]  run_ctl_wr_in,
    input  wire logic [2:0]  run_ctl_wdata_in,
    input  wire logic [2:0]  underflow_flag_clr_in,
    input  wire logic [2:0]  underflow_irq_en_in,
    output logic      [47:0] reload_value_out,
    output logic      [47:0] count_out,
    output logic      [2:0]  run_ctl_out,
    output logic      [2:0]  timer_preset_out,
    output logic      [2:0]  underflow_flag_out,
    output logic      [2:0]  irq_out,
    output logic             adc_trigger_out,
    output logic             spi_clk_src_out,
    output logic             i2c_clk_src_out
);
    // ******************************************************
    // Reload registers
    // ******************************************************
    logic [47:0] reload_q;

    // Full-range writable, reset to zero
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reload_q <= {RDT_NUM_CH{RDT_RELOAD_RST}};
        end else begin
            for (int i = 0; i < RDT_NUM_CH; i++) begin
                if (reload_wr_in[i]) begin
                    reload_q[i*16 +: 16] <= reload_wdata_in[i*16 +: 16];
                end
            end
        end
    end

    // Preset is write-only; its read view is a constant zero register
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            timer_preset_out <= 3'h0;
        end else begin
            timer_preset_out <= 3'h0;
        end
    end

    // ******************************************************
    // Channels
    // ******************************************************
    logic [47:0] cnt_w;
    logic [2:0]  run_w;
    logic [2:0]  uf_w;
    logic [2:0]  flag_w;
    logic [2:0]  irq_w;

    rdt_ctl_if ch_if [RDT_NUM_CH] ();

    // Same channel instantiated three times
    for (genvar g = 0; g < RDT_NUM_CH; g++) begin : g_ch
        assign ch_if[g].clk_div_sel      = clk_div_sel_in[g*4 +: 4];
        assign ch_if[g].oneshot_sel      = oneshot_sel_in[g];
        assign ch_if[g].reload_value     = reload_q[g*16 +: 16];
        assign ch_if[g].timer_preset     = timer_preset_in[g];
        assign ch_if[g].run_wr           = run_ctl_wr_in[g];
        assign ch_if[g].run_wdata        = run_ctl_wdata_in[g];
        assign ch_if[g].flag_clr         = underflow_flag_clr_in[g];
        assign ch_if[g].underflow_irq_en = underflow_irq_en_in[g];
        assign cnt_w[g*16 +: 16]         = ch_if[g].count;
        assign run_w[g]                  = ch_if[g].running;
        assign uf_w[g]                   = ch_if[g].underflow;
        assign flag_w[g]                 = ch_if[g].underflow_flag;
        assign irq_w[g]                  = ch_if[g].irq;

        rdt_channel u_ch (
            .clk_in  (clk_in),
            .rstn_in (rstn_in),
            .ctl     (ch_if[g])
        );
    end

    // ******************************************************
    // Outputs
    // ******************************************************
    // Channel state already registered; pulses routed per consumer
    always_comb begin
        reload_value_out   = reload_q;
        count_out          = cnt_w;
        run_ctl_out        = run_w;
        underflow_flag_out = flag_w;
        irq_out            = irq_w;
        adc_trigger_out    = uf_w[RDT_CH_ADC];
        spi_clk_src_out    = uf_w[RDT_CH_SPI];
        i2c_clk_src_out    = uf_w[RDT_CH_I2C];
    end
endmodule

// >>> tb/rdt_consumer.sv
// Far-side consumers: converter, SPI and I2C master tally trigger pulses.
// Assumes one-cycle pulses synchronous to the peripheral clock.
`timescale 1ns/1ps
module rdt_consumer (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic [2:0]  pulse_in,
    output logic      [47:0] seen_out
);
    // Each consumer acts once per pulse, so a stuck pulse overcounts
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seen_out <= 48'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                seen_out[16*i+:16] <= seen_out[16*i+:16] + 16'(pulse_in[i]);
            end
        end
    end
endmodule

// >>> tb/rdt_top_props.sv
// Concurrent checks on the timer top ports, watched through channel 0; request and preset checks cover all three.
// Assumes the bench holds reload and divider steady while running.
`timescale 1ns/1ps
module rdt_props (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic [11:0] clk_div_sel_in,
    input  wire logic [2:0]  oneshot_sel_in,
    input  wire logic [2:0]  timer_preset_in,
    input  wire logic [2:0]  run_ctl_wr_in,
    input  wire logic [2:0]  underflow_flag_clr_in,
    input  wire logic [2:0]  underflow_irq_en_in,
    input  wire logic [47:0] reload_value_out,
    input  wire logic [47:0] count_out,
    input  wire logic [2:0]  run_ctl_out,
    input  wire logic [2:0]  timer_preset_out,
    input  wire logic [2:0]  underflow_flag_out,
    input  wire logic [2:0]  irq_out,
    input  wire logic        adc_trigger_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // ****
    // Channel 0 steps
    // ****
    sequence s_tick0;
        run_ctl_out[0] && clk_div_sel_in[3:0] == 4'h0 &&
        count_out[15:0] != 16'h0000 && !timer_preset_in[0] &&
        !run_ctl_wr_in[0];
    endsequence
    // Underflow not overridden by a run write in the same cycle
    sequence s_uf0;
        adc_trigger_out && !$past(run_ctl_wr_in[0]);
    endsequence
    a_count_steps_down: assert property (
        s_tick0 |=> count_out[15:0] == $past(count_out[15:0]) - 16'h0001)
        else $error("count did not step down by one");
    a_uf_reloads: assert property (
        adc_trigger_out |-> count_out[15:0] == reload_value_out[15:0])
        else $error("underflow without reload");
    a_pulse_one_wide: assert property (
        adc_trigger_out |=> !adc_trigger_out)
        else $error("trigger pulse wider than one cycle");
    a_uf_sets_flag: assert property (
        adc_trigger_out |-> underflow_flag_out[0])
        else $error("flag not set on underflow");
    a_oneshot_stops: assert property (
        s_uf0 ##0 $past(oneshot_sel_in[0]) |-> !run_ctl_out[0])
        else $error("one-shot kept running");
    a_repeat_runs: assert property (
        s_uf0 ##0 !$past(oneshot_sel_in[0]) |-> run_ctl_out[0])
        else $error("repeat mode stopped");
    a_stop_holds: assert property (
        !run_ctl_out[0] && !timer_preset_in[0] |=> $stable(count_out[15:0]))
        else $error("stopped counter moved");
    a_irq_gated: assert property (
        (irq_out & ~$past(underflow_irq_en_in)) == 3'h0)
        else $error("request while disabled");
    a_flag_clears: assert property (
        underflow_flag_clr_in[0] |=> !underflow_flag_out[0] || adc_trigger_out)
        else $error("flag not cleared");
    a_preset_reads0: assert property (
        timer_preset_out == 3'h0)
        else $error("preset bit read back nonzero");
endmodule
bind rdt_top rdt_props i_rdt_props (.clk_in, .rstn_in, .clk_div_sel_in,
    .oneshot_sel_in, .timer_preset_in, .run_ctl_wr_in, .underflow_flag_clr_in,
    .underflow_irq_en_in, .reload_value_out, .count_out, .run_ctl_out,
    .timer_preset_out, .underflow_flag_out, .irq_out, .adc_trigger_out);

// >>> tb/tb_top.sv
// Bench: random reload and divider, repeat then one-shot on all channels.
// Assumes the design files and rdt_consumer are compiled first.
`timescale 1ns/1ps
module tb_top;
    import rdt_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [11:0] div = 12'h000;
    logic [47:0] rd = 48'h0, rv, cnt, seen, s0;
    logic [2:0]  os = 3'h0, rw = 3'h0, pre = 3'h0, rwr = 3'h0;
    logic [2:0]  rwd = 3'h0, clr = 3'h0, en = 3'h5;
    logic [2:0]  run, po, flg, irq;
    wire  [2:0]  puls;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          seed = 84164;
    int          n;
    // Half period of 25 ns gives the 20 MHz peripheral clock
    always #25 clk = ~clk;
    rdt_top i_rdt_top (.clk_in(clk), .rstn_in(rstn), .clk_div_sel_in(div),
        .oneshot_sel_in(os), .reload_wr_in(rw), .reload_wdata_in(rd),
        .timer_preset_in(pre), .run_ctl_wr_in(rwr), .run_ctl_wdata_in(rwd),
        .underflow_flag_clr_in(clr), .underflow_irq_en_in(en),
        .reload_value_out(rv), .count_out(cnt), .run_ctl_out(run),
        .timer_preset_out(po), .underflow_flag_out(flg), .irq_out(irq),
        .adc_trigger_out(puls[0]), .spi_clk_src_out(puls[1]),
        .i2c_clk_src_out(puls[2]));
    rdt_consumer i_rdt_consumer (.clk_in(clk), .rstn_in(rstn),
        .pulse_in(puls), .seen_out(seen));
    // Cycles between underflows: reload plus one ticks of 2^code cycles
    function automatic int period(input logic [15:0] r, input logic [3:0] d);
        return (int'(r) + 1) << d;
    endfunction
    task automatic chk(input string nm, input logic [47:0] e, g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One-cycle strobe, driven off the sampling edge
    task automatic strobe(ref logic [2:0] s, input logic [2:0] v);
        @(negedge clk);
        s = v;
        @(negedge clk);
        s = 3'h0;
    endtask
    // Bounded wait for a channel pulse; n counts cycles waited
    task automatic wait_puls(input int ch);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (puls[ch] !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            chk("pulse_wait", 48'h0, 48'h1);
            test_done();
        end
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        chk("count_rst", {3{RDT_CNT_RST}}, cnt);
        chk("reload_rst", {3{RDT_RELOAD_RST}}, rv);
        chk("status_rst", 48'h0, {39'h0, run, flg, irq});
        chk("preset_rd", 48'h0, po);
        for (int k = 0; k < 2; k++) begin
            // Divider changes here and before the reserved-code run, each after the previous run stopped
            for (int i = 0; i < 3; i++) begin
                rd[16*i+:16] = 16'($random(seed)) & 16'h7;
                div[4*i+:4] = 4'($random(seed)) & 4'h3;
            end
            // Channel 0 corners: reload 0 at half rate, then reload 5
            rd[15:0] = 16'(5 * k);
            div[3:0] = 4'(1 - k);
            os = {3{k[0]}};
            strobe(rw, 3'h7);
            strobe(pre, 3'h7);
            @(negedge clk);
            chk("reload", rd, rv);
            chk("preset", rd, cnt);
            s0 = seen;
            rwd = 3'h7;
            strobe(rwr, 3'h7);
            if (k == 0) begin
                for (int i = 0; i < 3; i++) begin
                    wait_puls(i);
                    wait_puls(i);
                    chk("period", period(rd[16*i+:16], div[4*i+:4]),
                        n);
                end
                rwd = 3'h0;
                strobe(rwr, 3'h7);
                s0 = cnt;
                repeat (20) @(negedge clk);
                chk("hold", s0, cnt);
                chk("flags", 48'h7, flg);
                strobe(clr, 3'h1);
                @(negedge clk);
                chk("flag_clr", 48'h6, flg);
                chk("irq", 48'(en & 3'h6), irq);
                // Flags cleared before every channel is enabled
                strobe(clr, 3'h7);
                en = 3'h7;
            end else begin
                repeat (200) @(negedge clk);
                chk("os_run", 48'h0, run);
                chk("os_count", rd, cnt);
                chk("os_pulses", 48'h000100010001, seen - s0);
                chk("os_irq", 48'h7, irq);
            end
        end
        // Reserved divider code must never tick, even while running
        div[3:0] = RDT_DIV_RSVD;
        s0 = seen;
        strobe(rwr, 3'h1);
        repeat (40) @(negedge clk);
        chk("rsvd_run", 48'h1, run);
        chk("rsvd_count", rd, cnt);
        chk("rsvd_pulses", 48'h0, seen - s0);
        test_done();
    end
endmodule
